// ---- src/dacreg_pkg.sv ----
// constants, register map and state codes of the converter port and trim register bank
// assumes nothing beyond a SystemVerilog compiler; imported by dacreg_top only
package dacreg_pkg;

    // serial instruction word
    localparam int INSTR_BITS = 8;
    localparam int INSTR_RW_BIT = 7;
    localparam int ADDR_W = 5;

    // register addresses
    localparam logic [4:0] ADDR_DATA_CTRL = 5'h02;
    localparam logic [4:0] ADDR_I_GAIN = 5'h03;
    localparam logic [4:0] ADDR_I_FS = 5'h04;
    localparam logic [4:0] ADDR_I_CM = 5'h05;
    localparam logic [4:0] ADDR_Q_GAIN = 5'h06;
    localparam logic [4:0] ADDR_Q_FS = 5'h07;
    localparam logic [4:0] ADDR_Q_CM = 5'h08;
    localparam int REG_FIRST = 2;
    localparam int REG_COUNT = 7;

    // values after reset
    localparam logic [7:0] RST_DATA_CTRL = 8'h34;
    localparam logic [7:0] RST_TRIM = 8'h00;

    // defined bits per register, the rest is reserved
    localparam logic [7:0] MASK_DATA_CTRL = 8'hbf;
    localparam logic [7:0] MASK_GAIN = 8'h3f;
    localparam logic [7:0] MASK_RES = 8'hbf;

    // field positions
    localparam int BIT_TWOS = 7;
    localparam int BIT_PAIR_ORDER = 5;
    localparam int BIT_RISE_CHAN = 4;
    localparam int BIT_DUAL_BLOCK = 3;
    localparam int BIT_CLK_IN_EN = 2;
    localparam int BIT_CLK_OUT_EN = 1;
    localparam int BIT_CLK_BOOST_EN = 0;
    localparam int BIT_ONCHIP_EN = 7;
    localparam int CODE_MSB = 5;

    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_INSTR = 2'b01,
        SPI_DATA = 2'b10
    } dacreg_spi_state_t;

    function automatic logic [7:0] dacreg_mask(input logic [4:0] addr);
        case (addr)
            ADDR_DATA_CTRL: dacreg_mask = MASK_DATA_CTRL;
            ADDR_I_GAIN, ADDR_Q_GAIN: dacreg_mask = MASK_GAIN;
            ADDR_I_FS, ADDR_I_CM, ADDR_Q_FS, ADDR_Q_CM: dacreg_mask = MASK_RES;
            default: dacreg_mask = 8'h00;
        endcase
    endfunction

endpackage

// ---- src/dacreg_cfg_if.sv ----
// carrier between the register bank and the sample port: format, pairing and capture events
// assumes a single clock domain on both ends
`timescale 1ns/1ps
`default_nettype none
interface dacreg_cfg_if;
    logic twos;
    logic pair_order;
    logic rising_sel;
    logic cap_rise;
    logic cap_fall;
    modport ctl (output twos, output pair_order, output rising_sel, output cap_rise,
                 output cap_fall);
    modport port (input twos, input pair_order, input rising_sel, input cap_rise,
                  input cap_fall);
endinterface
`default_nettype wire

// ---- src/dacreg_edge_det.sv ----
// registered edge detector for a level that is synchronous to clock_in
// assumes the level holds for at least two clock cycles between changes
`timescale 1ns/1ps
`default_nettype none
module dacreg_edge_det (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // level and its edges
    input wire logic level_in,
    output logic rise_out,
    output logic fall_out
);
    logic prev_q;

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prev_q <= 1'b0;
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            prev_q <= level_in;
            rise_out <= level_in & ~prev_q;
            fall_out <= ~level_in & prev_q;
        end
    end
endmodule
`default_nettype wire

// ---- src/dacreg_sample_port.sv ----
// shared sample port: pairs I and Q words captured on both clock edges and
// hands them to the converter core as offset binary
// assumes capture events come from the pad clock as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module dacreg_sample_port #(
    parameter int DATA_W = 14
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // configuration and capture events
    dacreg_cfg_if.port cfg,
    // sample data
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] i_sample_out,
    output logic [DATA_W-1:0] q_sample_out,
    output logic sample_valid_out
);
    logic [DATA_W-1:0] first_q;
    logic first_valid_q;
    wire capture = cfg.cap_rise | cfg.cap_fall;
    // rising edge carries the selected channel, falling edge the other one
    wire is_i = cfg.cap_rise ? cfg.rising_sel : ~cfg.rising_sel; // see R4
    // with I first, the Q word closes the pair
    wire is_second = is_i ? ~cfg.pair_order : cfg.pair_order; // see R3
    // flipping the sign bit turns two's complement into offset binary
    wire [DATA_W-1:0] word = cfg.twos ? {~data_in[DATA_W-1], data_in[DATA_W-2:0]}
                                      : data_in; // see R1 see R2

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            first_q <= '0;
            first_valid_q <= 1'b0;
            i_sample_out <= '0;
            q_sample_out <= '0;
            sample_valid_out <= 1'b0;
        end else begin
            sample_valid_out <= 1'b0;
            if (capture && !is_second) begin
                first_q <= word;
                first_valid_q <= 1'b1;
            end else if (capture && first_valid_q) begin
                // a second word without a first one is dropped
                i_sample_out <= is_i ? word : first_q;
                q_sample_out <= is_i ? first_q : word;
                sample_valid_out <= 1'b1;
                first_valid_q <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/dacreg_top.sv ----
// top of the converter port and trim register bank: serial control port slave,
// register bank, sample clock pad control and the shared sample port
// assumes every pin is synchronous to clock_in and the serial clock is much slower
// Functional notes
// R1: data control bit 7 selects sample format; zero means unsigned binary.
// R2: format bit set makes every data word read as two's complement.
// R3: data control bit 5 picks pair order; one means I first.
// R4: data control bit 4 picks rising-edge channel; one means I.
// R5: data control bit 3 set forbids pad input and output together.
// R6: data control bit 2 enables the clock pad as input, default on.
// R7: data control bit 1 enables the regular clock output driver, default off.
// R8: data control bit 0 adds a parallel boost driver, default off.
// R9: address 0x03 holds the six-bit I fine gain, reset zero.
// R10: address 0x06 holds the six-bit Q fine gain, reset zero.
// R11: address 0x04 bit 7 selects on-chip I full-scale resistor.
// R12: address 0x04 bits 5:0 hold the two's complement I full-scale code.
// R13: address 0x05 bit 7 selects on-chip I common-mode resistor.
// R14: address 0x05 bits 5:0 hold the I common-mode resistor code.
// R15: address 0x07 bit 7 selects on-chip Q full-scale code in bits 5:0.
// R16: address 0x08 bits 5:0 hold the Q common-mode code, default zero.
// R17: reads return the last written value of every defined bit.
// R18: reserved bits ignore writes and read as zero.
// R19: analog control outputs follow stored values once the write completes.
`timescale 1ns/1ps
`default_nettype none
module dacreg_top
    import dacreg_pkg::*;
#(
    parameter int DATA_W = 14
) (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // serial control port, three-wire
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sdio_in,
    output logic spi_sdio_out,
    output logic spi_sdio_oe_out,
    // sample clock pad
    input wire logic sample_clock_pad_in,
    output logic sample_clock_pad_out,
    output logic sample_clock_pad_oe_out,
    output logic sample_clock_boost_oe_out,
    // sample data port
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] i_sample_out,
    output logic [DATA_W-1:0] q_sample_out,
    output logic sample_valid_out,
    // I channel analog controls
    output logic [5:0] i_fine_gain_word_out,
    output logic i_fs_onchip_en_out,
    output logic [5:0] i_fs_code_out,
    output logic i_cm_onchip_en_out,
    output logic [5:0] i_cm_code_out,
    // Q channel analog controls
    output logic [5:0] q_fine_gain_word_out,
    output logic q_fs_onchip_en_out,
    output logic [5:0] q_fs_code_out,
    output logic q_cm_onchip_en_out,
    output logic [5:0] q_cm_code_out
);
    // register storage, index 0 is the data control register
    // flops, not a memory: every field drives a control output at once
    logic [7:0] regs_q [REG_COUNT];

    // serial engine state
    dacreg_spi_state_t state_q;
    dacreg_spi_state_t state_d;
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic [4:0] addr_q;
    logic rd_q;
    logic sdio_out_q;
    logic sdio_oe_q;

    // pad control state
    // the toggle rests low whenever no driver is enabled
    logic pad_toggle_q;
    logic pad_oe_q;
    logic boost_oe_q;

    // serial clock edges
    logic sclk_rise;
    logic sclk_fall;

    // both serial clock edges become one-cycle events
    dacreg_edge_det u_sclk_edge (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .level_in(spi_clk_in),
        .rise_out(sclk_rise),
        .fall_out(sclk_fall)
    );

    // decoding of the serial stream
    // sdio is taken a cycle after the rise is seen: hold it two cycles
    wire selected = ~spi_cs_n_in;
    wire bit_in = selected & sclk_rise;
    wire [7:0] rx_next = {rx_q[6:0], spi_sdio_in};
    wire byte_done = bit_in & (bit_cnt_q == 3'h7);
    wire instr_done = byte_done & (state_q == SPI_INSTR);
    wire data_done = byte_done & (state_q == SPI_DATA);

    // what each completed byte does
    wire [4:0] addr_inc = addr_q + 5'h01;
    wire wr_commit = data_done & ~rd_q;
    wire rd_load = instr_done ? rx_next[INSTR_RW_BIT] : (data_done & rd_q);
    wire [4:0] rd_addr = instr_done ? rx_next[ADDR_W-1:0] : addr_inc;
    wire shift_out = selected & sclk_fall & rd_q & (state_q == SPI_DATA);

    // read path: unmapped addresses and reserved bits answer zero
    // the word is fetched at the rise ending a byte, before the first fall
    wire rd_in_map = (rd_addr >= ADDR_DATA_CTRL) && (rd_addr <= ADDR_Q_CM);
    wire [4:0] rd_off = rd_addr - ADDR_DATA_CTRL;
    wire [2:0] rd_idx = rd_off[2:0];
    wire [7:0] rd_data = rd_in_map ? (regs_q[rd_idx] & dacreg_mask(rd_addr))
                                   : 8'h00; // see R17 see R18

    // write path: only defined bits are stored
    // addr_q is still the address of this byte; it steps afterwards
    wire [7:0] wr_data = rx_next & dacreg_mask(addr_q); // see R18

    // a deselect at any point returns to the idle phase
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            SPI_IDLE: begin
                if (selected) begin
                    state_d = SPI_INSTR;
                end
            end
            SPI_INSTR: begin
                if (!selected) begin
                    state_d = SPI_IDLE;
                end else if (instr_done) begin
                    state_d = SPI_DATA;
                end
            end
            SPI_DATA: begin
                if (!selected) begin
                    state_d = SPI_IDLE;
                end
            end
            default: state_d = SPI_IDLE;
        endcase
    end

    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q <= SPI_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // bit counter and receive shifter; deselect aborts a partial byte
    // rx keeps stale bits across frames; only the count says what is valid
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            bit_cnt_q <= 3'h0;
            rx_q <= 8'h00;
        end else if (!selected) begin
            bit_cnt_q <= 3'h0;
        end else if (bit_in) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_q <= rx_next;
        end
    end

    // address and direction: the address steps after every data byte
    // streaming wraps at the top of the five-bit address space
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            addr_q <= 5'h00;
            rd_q <= 1'b0;
        end else if (!selected) begin
            rd_q <= 1'b0;
        end else if (instr_done) begin
            addr_q <= rx_next[ADDR_W-1:0];
            rd_q <= rx_next[INSTR_RW_BIT];
        end else if (data_done) begin
            addr_q <= addr_inc;
        end
    end

    // transmit shifter: new bits leave on the falling serial clock edge
    // the fall after the last byte shifts one spare bit that no host samples
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_q <= 8'h00;
            sdio_out_q <= 1'b0;
            sdio_oe_q <= 1'b0;
        end else if (!selected) begin
            sdio_oe_q <= 1'b0;
            sdio_out_q <= 1'b0;
        end else if (rd_load) begin
            tx_q <= rd_data; // see R17
        end else if (shift_out) begin
            sdio_out_q <= tx_q[7];
            sdio_oe_q <= 1'b1;
            tx_q <= {tx_q[6:0], 1'b0};
        end
    end

    assign spi_sdio_out = sdio_out_q;
    assign spi_sdio_oe_out = sdio_oe_q;

    // register bank, one flop group per address
    // reserved bits never reach the flops, so they cannot read back as one
    for (genvar g = 0; g < REG_COUNT; g++) begin : g_reg
        localparam logic [7:0] RST_VAL = (g == 0) ? RST_DATA_CTRL : RST_TRIM;
        wire hit = wr_commit & (addr_q == 5'(REG_FIRST + g));
        always_ff @(posedge clock_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
                regs_q[g] <= RST_VAL;
            end else if (hit) begin
                regs_q[g] <= wr_data; // see R17 see R19
            end
        end
    end

    // named views of the data control register
    wire [7:0] ctrl = regs_q[0];
    wire clk_in_en = ctrl[BIT_CLK_IN_EN]; // see R6
    wire clk_out_req = ctrl[BIT_CLK_OUT_EN] | ctrl[BIT_CLK_BOOST_EN]; // see R7 see R8

    // with the block bit and the input enable both set the input keeps the pad and the drivers stay off
    wire out_blocked = ctrl[BIT_DUAL_BLOCK] & clk_in_en; // see R5
    wire pad_oe_d = clk_out_req & ~out_blocked;
    wire boost_oe_d = ctrl[BIT_CLK_BOOST_EN] & ~out_blocked; // see R8

    // pad drivers; the output clock runs at half of clock_in
    // the boost driver only ever joins the regular one, never drives alone
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pad_toggle_q <= 1'b0;
            pad_oe_q <= 1'b0;
            boost_oe_q <= 1'b0;
        end else begin
            pad_toggle_q <= pad_oe_d ? ~pad_toggle_q : 1'b0;
            pad_oe_q <= pad_oe_d; // see R7
            boost_oe_q <= boost_oe_d;
        end
    end

    assign sample_clock_pad_out = pad_toggle_q;
    assign sample_clock_pad_oe_out = pad_oe_q;
    assign sample_clock_boost_oe_out = boost_oe_q;

    // capture clock: the pad input when enabled, else our own driven clock
    // limitation: with no input and no driver enabled nothing is captured
    wire cap_level = clk_in_en ? sample_clock_pad_in
                               : (pad_oe_q & pad_toggle_q); // see R6

    dacreg_cfg_if cfg_if ();

    dacreg_edge_det u_cap_edge (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .level_in(cap_level),
        .rise_out(cfg_if.cap_rise),
        .fall_out(cfg_if.cap_fall)
    );

    // format and order apply from the next capture after the write
    assign cfg_if.twos = ctrl[BIT_TWOS]; // see R1 see R2
    assign cfg_if.pair_order = ctrl[BIT_PAIR_ORDER]; // see R3
    assign cfg_if.rising_sel = ctrl[BIT_RISE_CHAN]; // see R4

    // the sample port sees only format, order, rising-edge channel and the capture events
    dacreg_sample_port #(
        .DATA_W(DATA_W)
    ) u_port (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .cfg(cfg_if.port),
        .data_in(data_in),
        .i_sample_out(i_sample_out),
        .q_sample_out(q_sample_out),
        .sample_valid_out(sample_valid_out)
    );

    // analog controls come straight from the stored fields
    // no shadow stage: a trim moves on the clock after its byte completes
    // I channel
    assign i_fine_gain_word_out = regs_q[1][CODE_MSB:0]; // see R9 see R19
    assign i_fs_onchip_en_out = regs_q[2][BIT_ONCHIP_EN]; // see R11
    assign i_fs_code_out = regs_q[2][CODE_MSB:0]; // see R12
    assign i_cm_onchip_en_out = regs_q[3][BIT_ONCHIP_EN]; // see R13
    assign i_cm_code_out = regs_q[3][CODE_MSB:0]; // see R14

    // Q channel
    assign q_fine_gain_word_out = regs_q[4][CODE_MSB:0]; // see R10 see R19
    assign q_fs_onchip_en_out = regs_q[5][BIT_ONCHIP_EN]; // see R15
    assign q_fs_code_out = regs_q[5][CODE_MSB:0]; // see R15
    assign q_cm_onchip_en_out = regs_q[6][BIT_ONCHIP_EN];
    assign q_cm_code_out = regs_q[6][CODE_MSB:0]; // see R16

endmodule
`default_nettype wire

// ---- tb/dacreg_assertions.sv ----
// checker on the dacreg_top ports: pad drivers, sample pulses, serial read timing
// assumes it is bound onto dacreg_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dacreg_assertions (
    // clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // serial port
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sdio_out,
    input wire logic spi_sdio_oe_out,
    // pad and samples
    input wire logic sample_clock_pad_in,
    input wire logic sample_clock_pad_out,
    input wire logic sample_clock_pad_oe_out,
    input wire logic sample_clock_boost_oe_out,
    input wire logic sample_valid_out,
    // trims
    input wire logic [5:0] i_fine_gain_word_out,
    input wire logic [5:0] q_fine_gain_word_out,
    input wire logic [5:0] i_fs_code_out,
    input wire logic [5:0] q_cm_code_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    // saturates so an old edge never wraps back into range
    logic [2:0] since_q;
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) since_q <= 3'h7;
        else if ($changed(sample_clock_pad_in)) since_q <= 3'h0;
        else if (since_q != 3'h7) since_q <= since_q + 3'h1;
    end
    a_reset_defaults: assert property ($fell(sys_rst_in) |->
        !sample_clock_pad_oe_out && !sample_clock_boost_oe_out && i_fine_gain_word_out == 6'h00
        && q_fine_gain_word_out == 6'h00 && i_fs_code_out == 6'h00 && q_cm_code_out == 6'h00)
        else $error("outputs not at defaults after reset");
    a_boost_needs_main: assert property (sample_clock_boost_oe_out |-> sample_clock_pad_oe_out)
        else $error("boost driver on without main driver");
    a_pad_toggles: assert property (sample_clock_pad_oe_out && $past(sample_clock_pad_oe_out)
        |-> sample_clock_pad_out != $past(sample_clock_pad_out))
        else $error("driven pad clock not toggling");
    a_valid_single: assert property (sample_valid_out |=> !sample_valid_out)
        else $error("sample valid longer than one cycle");
    a_valid_after_edge: assert property (sample_valid_out && !sample_clock_pad_oe_out
        |-> since_q <= 3'h4) else $error("sample pair without a recent pad edge");
    a_regs_quiet: assert property (spi_cs_n_in && $past(spi_cs_n_in) && $past(spi_cs_n_in, 2)
        |-> $stable(i_fine_gain_word_out) && $stable(q_fine_gain_word_out)
        && $stable(i_fs_code_out) && $stable(q_cm_code_out))
        else $error("trim output moved with the serial port idle");
    a_sdio_oe_idle: assert property (spi_cs_n_in && $past(spi_cs_n_in) && $past(spi_cs_n_in, 2)
        |-> !spi_sdio_oe_out) else $error("serial data driven while deselected");
    a_sdio_on_low: assert property (spi_sdio_oe_out && $changed(spi_sdio_out)
        |-> !$past(spi_clk_in)) else $error("read data moved while serial clock high");
endmodule
bind dacreg_top dacreg_assertions u_chk (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .spi_clk_in(spi_clk_in),
    .spi_cs_n_in(spi_cs_n_in), .spi_sdio_out(spi_sdio_out), .spi_sdio_oe_out(spi_sdio_oe_out),
    .sample_clock_pad_in(sample_clock_pad_in), .sample_clock_pad_out(sample_clock_pad_out),
    .sample_clock_pad_oe_out(sample_clock_pad_oe_out),
    .sample_clock_boost_oe_out(sample_clock_boost_oe_out), .sample_valid_out(sample_valid_out),
    .i_fine_gain_word_out(i_fine_gain_word_out), .q_fine_gain_word_out(q_fine_gain_word_out),
    .i_fs_code_out(i_fs_code_out), .q_cm_code_out(q_cm_code_out)
);
`default_nettype wire

// ---- tb/dacreg_host_model.sv ----
// serial host and sample source facing dacreg_top
// assumes the bench resolves the shared sdio and pad wires; moves only at falling clock edges
`timescale 1ns/1ps
`default_nettype none
module dacreg_host_model (
    // clock and resolved wires
    input wire logic clock_in,
    input wire logic sdio_in,
    // serial port
    output logic spi_clk_out,
    output logic spi_cs_n_out,
    output logic sdio_out,
    // sample port
    output logic pad_out,
    output logic [13:0] data_out
);
    initial begin
        spi_clk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        sdio_out = 1'b0;
        pad_out = 1'b0;
        data_out = 14'h0000;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    // serial clock high and low four cycles each, above the two the port needs
    task automatic spi_xfer(input logic [7:0] instr, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {instr, wd};
        spi_cs_n_out = 1'b0;
        wait_n(3);
        for (int b = 15; b >= 0; b--) begin
            spi_clk_out = 1'b0;
            // released during read data: keep the line moving so no stale bit reads back
            sdio_out = (instr[7] && b < 8) ? ~sdio_out : sh[b];
            wait_n(4);
            spi_clk_out = 1'b1;
            if (b < 8) rd[b] = sdio_in;
            wait_n(4);
        end
        spi_clk_out = 1'b0;
        sdio_out = ~sdio_out;
        wait_n(4);
        spi_cs_n_out = 1'b1;
        wait_n(4);
    endtask
    // one word per pad edge, held well past the capture
    task automatic pad_edge(input logic [13:0] w);
        data_out = w;
        wait_n(1);
        pad_out = ~pad_out;
        wait_n(4);
        data_out = ~w;
        wait_n(1);
    endtask
endmodule
`default_nettype wire

// ---- tb/dacreg_tb.sv ----
// self-checking bench for dacreg_top: register map, pad drivers, sample pairing
// assumes dacreg_host_model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module dacreg_tb;
    logic clock_in, sys_rst_in, spi_clk, spi_cs_n, host_sdio, sdio_out, sdio_oe, sdio_wire;
    logic pad_host, pad_out, pad_oe, boost_oe, pad_wire, valid, ifs_en, icm_en, qfs_en, qcm_en;
    logic fr;
    logic [13:0] data, i_s, q_s, got_i, got_q, wi, wq;
    logic [5:0] ig, ifs, icm, qg, qfs, qcm;
    logic [7:0] sh [2:8];
    logic [7:0] codes [4] = '{8'h80, 8'h9f, 8'ha0, 8'hff};
    int fails, num_checks, seed, nvalid, base;
    wire logic [39:0] trim_bus = {ig, ifs_en, ifs, icm_en, icm, qg, qfs_en, qfs, qcm_en, qcm};
    assign sdio_wire = sdio_oe ? sdio_out : host_sdio;
    assign pad_wire = pad_oe ? pad_out : pad_host;
    dacreg_top #(.DATA_W(14)) dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .spi_clk_in(spi_clk),
        .spi_cs_n_in(spi_cs_n), .spi_sdio_in(sdio_wire), .spi_sdio_out(sdio_out),
        .spi_sdio_oe_out(sdio_oe), .sample_clock_pad_in(pad_wire), .sample_clock_pad_out(pad_out),
        .sample_clock_pad_oe_out(pad_oe), .sample_clock_boost_oe_out(boost_oe), .data_in(data),
        .i_sample_out(i_s), .q_sample_out(q_s), .sample_valid_out(valid),
        .i_fine_gain_word_out(ig), .i_fs_onchip_en_out(ifs_en), .i_fs_code_out(ifs),
        .i_cm_onchip_en_out(icm_en), .i_cm_code_out(icm), .q_fine_gain_word_out(qg),
        .q_fs_onchip_en_out(qfs_en), .q_fs_code_out(qfs), .q_cm_onchip_en_out(qcm_en),
        .q_cm_code_out(qcm)
    );
    dacreg_host_model host (
        .clock_in(clock_in), .sdio_in(sdio_wire), .spi_clk_out(spi_clk),
        .spi_cs_n_out(spi_cs_n), .sdio_out(host_sdio), .pad_out(pad_host), .data_out(data)
    );
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    always @(negedge clock_in) begin
        if (valid === 1'b1) begin
            got_i = i_s;
            got_q = q_s;
            nvalid++;
        end
    end
    function automatic logic [7:0] mask_of(input int a);
        return (a == 3 || a == 6) ? 8'h3f : (a >= 2 && a <= 8) ? 8'hbf : 8'h00;
    endfunction
    function automatic logic [39:0] exp_trims();
        return {sh[3][5:0], sh[4][7], sh[4][5:0], sh[5][7], sh[5][5:0],
                sh[6][5:0], sh[7][7], sh[7][5:0], sh[8][7], sh[8][5:0]};
    endfunction
    function automatic logic pad_en(input int m);
        return (m[1] | m[0]) & ~(m[3] & m[2]);
    endfunction
    function automatic logic [13:0] samp(input logic [13:0] w, input logic t);
        return {w[13] ^ t, w[12:0]};
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input int a, input logic [7:0] v);
        logic [7:0] d;
        host.spi_xfer({3'h0, 5'(a)}, v, d);
        if (a >= 2 && a <= 8) sh[a] = v & mask_of(a);
    endtask
    task automatic rd_chk(input int a);
        logic [7:0] d;
        host.spi_xfer({3'h4, 5'(a)}, 8'h00, d);
        chk(d, (a >= 2 && a <= 8) ? sh[a] : 8'h00, "readback");
    endtask
    task automatic do_reset();
        sys_rst_in = 1'b1;
        repeat (4) @(negedge clock_in);
        sys_rst_in = 1'b0;
        sh[2] = 8'h34;
        for (int a = 3; a <= 8; a++) sh[a] = 8'h00;
        repeat (2) @(negedge clock_in);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock_in);
        fails++;
        $display("BAD %0t watchdog expired", $time);
        summarize();
    end
    initial begin
        seed = 65418;
        fails = 0;
        num_checks = 0;
        nvalid = 0;
        do_reset();
        chk(trim_bus, exp_trims(), "trims after reset");
        for (int a = 1; a <= 9; a++) rd_chk(a);
        for (int a = 1; a <= 9; a++) begin
            wr(a, 8'hff);
            rd_chk(a);
            wr(a, 8'($random(seed)));
            rd_chk(a);
            chk(trim_bus, exp_trims(), "trim outputs");
        end
        foreach (codes[k]) begin
            for (int a = 4; a <= 8; a++) if (a != 6) wr(a, codes[k]);
            chk(trim_bus, exp_trims(), "resistor codes");
        end
        for (int m = 0; m < 16; m++) begin
            wr(2, 8'h30 | 8'(m));
            chk({pad_oe, boost_oe}, {pad_en(m), pad_en(m) & m[0]}, "pad drivers");
        end
        // own-clock captures above may leave half a pair stored
        do_reset();
        rd_chk(2);
        for (int k = 0; k < 8; k++) begin
            wr(2, {k[2], 1'b0, k[1], k[0], 4'h4});
            wi = 14'($random(seed));
            wq = 14'($random(seed));
            if (k == 7) wi = 14'h2000;
            fr = (k[1] == k[0]);
            base = nvalid;
            // wrong edge next: send a lone second-channel word, which must be dropped
            if (pad_host == fr) host.pad_edge(~wi);
            host.pad_edge(k[1] ? wi : wq);
            host.pad_edge(k[1] ? wq : wi);
            chk(64'(nvalid - base), 64'h1, "pair count");
            chk({got_i, got_q}, {samp(wi, k[2]), samp(wq, k[2])}, "pair data");
        end
        summarize();
    end
endmodule
`default_nettype wire
